// >>> hw/rbc_top.sv
// Reset sequencer, boot strap capture, regulator and clock mode control.
// Assumes pins arrive asynchronously; event inputs are on aclk.
`timescale 1ns/1ps
module rbc_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        reset_pin_n,
    input  wire logic        boot_mode_strap_pin,
    input  wire logic        jtag_mode_select,
    input  wire logic        port_zero_bit_zero_strap,
    input  wire logic        flash_protected,
    input  wire logic        watchdog_timer_reset_req,
    input  wire logic        brownout_detect,
    input  wire logic        osc_running,
    input  wire logic        pll_locked,
    output logic             system_reset_n,
    output logic             sram_preserved,
    output logic             main_regulator_en,
    output logic             lp_regulator_en,
    output logic             ext_osc_select,
    output logic [1:0]       clock_mode,
    output logic [4:0]       feedback_ndiv,
    output logic [1:0]       div_p,
    output logic [1:0]       div_k,
    output logic [1:0]       boot_mode,
    output logic [15:0]      pc_start,
    output logic             clock_fault,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    typedef enum logic [1:0] {ST_RESET, ST_RUN, ST_PDOWN} rbc_state_t;

    function automatic rbc_pkg::rbc_boot_t boot_decode(
        input logic boot_pin, input logic sel_pin, input logic p0_pin,
        input logic prot);
        rbc_pkg::rbc_boot_t m;
        m = rbc_pkg::BOOT_USER;
        if (!sel_pin)
            m = boot_pin ? rbc_pkg::BOOT_USER : rbc_pkg::BOOT_LOADER;
        else if (!p0_pin)
        begin
            m = boot_pin ? rbc_pkg::BOOT_USER_JTAG
                         : rbc_pkg::BOOT_DEBUG;
            if (!boot_pin && prot)
                m = rbc_pkg::BOOT_USER;
        end
        return m;
    endfunction : boot_decode

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // A change is accepted only when stages two and three agree, which
    // rejects a single metastable sample at the cost of one cycle.
    logic [3:0] pin_raw;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] pin_lvl;
    assign pin_raw = {reset_pin_n, boot_mode_strap_pin, jtag_mode_select,
                      port_zero_bit_zero_strap};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_sync
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    sync1[gi]   <= 1'b1;
                    sync2[gi]   <= 1'b1;
                    sync3[gi]   <= 1'b1;
                    pin_lvl[gi] <= 1'b1;
                end
                else
                begin
                    sync1[gi] <= pin_raw[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                    if (sync2[gi] == sync3[gi])
                        pin_lvl[gi] <= sync3[gi];
                end
            end
        end
    endgenerate

    logic pin_reset;
    assign pin_reset = !pin_lvl[3];

    // ****************************************
    // Reset sequencer
    // ****************************************
    rbc_state_t                 state;
    logic [rbc_pkg::CAUSE_N-1:0] cur_cause;
    logic [rbc_pkg::CAUSE_N-1:0] next_cause;
    logic [rbc_pkg::CAUSE_N-1:0] cause_flags;
    logic [4:0]                 hold_cnt;
    logic                       reset_req;
    logic                       pdown_req;
    logic                       seq_done;

    assign reset_req = pin_reset || watchdog_timer_reset_req || brownout_detect;
    assign seq_done  = (state == ST_RESET) && !pin_reset && !brownout_detect
                       && (hold_cnt == 5'(rbc_pkg::RST_HOLD_CYC - 1));

    always_comb
    begin
        next_cause = '0;
        if (state == ST_PDOWN)
            next_cause[rbc_pkg::CAUSE_WAKE] = 1'b1;
        else if (brownout_detect)
            next_cause[rbc_pkg::CAUSE_BO] = 1'b1;
        else if (pin_reset)
            next_cause[rbc_pkg::CAUSE_HW] = 1'b1;
        else
            next_cause[rbc_pkg::CAUSE_WDOG] = 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state     <= ST_RESET;
            cur_cause <= 5'h0_001;
        end
        else
        begin
            case (state)
                ST_RESET:
                    if (seq_done)
                        state <= ST_RUN;
                ST_RUN:
                    if (reset_req)
                    begin
                        state     <= ST_RESET;
                        cur_cause <= next_cause;
                    end
                    else if (pdown_req)
                        state <= ST_PDOWN;
                ST_PDOWN:
                    if (reset_req)
                    begin
                        state     <= ST_RESET;
                        cur_cause <= next_cause;
                    end
                default:
                    state <= ST_RESET;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || state != ST_RESET || pin_reset || brownout_detect)
            hold_cnt <= '0;
        else if (!seq_done)
            hold_cnt <= hold_cnt + 5'h0_001;
    end

    // Core and peripherals share one reset for every cause.
    assign system_reset_n = (state != ST_RESET);
    assign pc_start       = rbc_pkg::PC_START;

    // ****************************************
    // Boot capture and SRAM state
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            boot_mode <= rbc_pkg::BOOT_USER;
        else if (seq_done && (cur_cause[rbc_pkg::CAUSE_POR]
                              || cur_cause[rbc_pkg::CAUSE_HW]))
            boot_mode <= boot_decode(pin_lvl[2], pin_lvl[1], pin_lvl[0],
                                     flash_protected);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sram_preserved <= 1'b0;
        else if (state == ST_RESET)
            sram_preserved <= !(cur_cause[rbc_pkg::CAUSE_POR]
                                || cur_cause[rbc_pkg::CAUSE_BO]);
    end

    // ****************************************
    // Regulators and clock control
    // ****************************************
    assign main_regulator_en = (state != ST_PDOWN);
    assign lp_regulator_en   = 1'b1;

    logic       osc_disc;
    logic       vco_byp;
    logic       osc_fail;
    logic       pll_unlock;

    always_comb
    begin
        if (osc_disc)
            clock_mode = rbc_pkg::CLK_PLL_BASE;
        else if (vco_byp)
            clock_mode = rbc_pkg::CLK_PRESCALER;
        else
            clock_mode = rbc_pkg::CLK_PLL;
    end
    assign div_p       = rbc_pkg::DIV_P_FIXED;
    assign div_k       = rbc_pkg::DIV_K_FIXED;
    assign clock_fault = osc_fail || pll_unlock;

    // ****************************************
    // AXI4-Lite register port
    // ****************************************
    logic        aw_held;
    logic        w_held;
    logic [3:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_go;
    logic        wr_ctrl;
    logic        wr_cause;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go    = aw_held && w_held && !s_axi_bvalid;
    // Strobes are held with the data, since the master may drop them once
    // the data channel has been taken.
    assign wr_ctrl  = wr_go && aw_addr == rbc_pkg::CTRL_OFFSET;
    assign wr_cause = wr_go && aw_addr == rbc_pkg::CAUSE_OFFSET;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            w_strb  <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (wr_go)
                aw_held <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (wr_go)
                w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= rbc_pkg::RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr == rbc_pkg::CTRL_OFFSET || wr_cause)
                            ? rbc_pkg::RESP_OKAY : rbc_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Control bits return to defaults on every internal reset.
    always_ff @(posedge aclk)
    begin
        if (!aresetn || state == ST_RESET)
        begin
            ext_osc_select <= 1'b0;
            osc_disc       <= 1'b0;
            vco_byp        <= 1'b0;
            feedback_ndiv  <= rbc_pkg::NDIV_RESET;
            pdown_req      <= 1'b0;
        end
        else
        begin
            pdown_req <= 1'b0;
            if (wr_ctrl && w_strb[0])
            begin
                ext_osc_select <= w_data[rbc_pkg::CTRL_EXT_OSC_BIT];
                osc_disc       <= w_data[rbc_pkg::CTRL_OSC_DISC_BIT];
                vco_byp        <= w_data[rbc_pkg::CTRL_VCO_BYP_BIT];
                pdown_req      <= w_data[rbc_pkg::CTRL_PDOWN_BIT];
            end
            if (wr_ctrl && w_strb[1])
                feedback_ndiv <= w_data[rbc_pkg::CTRL_NDIV_LSB+:
                                        rbc_pkg::NDIV_W];
        end
    end

    // Sticky flags: a new event wins over a clear in the same cycle.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cause_flags <= 5'h0_001;
            osc_fail    <= 1'b0;
            pll_unlock  <= 1'b0;
        end
        else
        begin
            if (state != ST_RESET && reset_req)
                cause_flags <= (wr_cause ? cause_flags & ~w_data[4:0]
                                         : cause_flags) | next_cause;
            else if (wr_cause)
                cause_flags <= cause_flags & ~w_data[4:0];
            osc_fail   <= !osc_running
                          || (osc_fail && !(wr_cause && w_data[8]));
            pll_unlock <= !pll_locked
                          || (pll_unlock && !(wr_cause && w_data[9]));
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= rbc_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= rbc_pkg::RESP_OKAY;
            s_axi_rdata  <= '0;
            case (s_axi_araddr)
                rbc_pkg::CTRL_OFFSET:
                    s_axi_rdata <= {19'h0_0000, feedback_ndiv, 5'h0_0,
                                    vco_byp, osc_disc, ext_osc_select};
                rbc_pkg::STATUS_OFFSET:
                    s_axi_rdata <= {20'h0_0000, state == ST_PDOWN,
                                    sram_preserved, pll_unlock, osc_fail,
                                    2'h0, clock_mode, 2'h0, boot_mode};
                rbc_pkg::CAUSE_OFFSET:
                    s_axi_rdata <= {27'h000_0000, cause_flags};
                default:
                    s_axi_rresp <= rbc_pkg::RESP_SLVERR;
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_pd_reset;
        state == ST_PDOWN && reset_req;
    endsequence

    a_pdown_wake_cause: assert property (@(posedge aclk) disable iff (!aresetn)
        s_pd_reset |=> cur_cause[rbc_pkg::CAUSE_WAKE] && state == ST_RESET)
        else $error("Reset in power-down not classed as wake-up.");
    a_wake_main_on: assert property (@(posedge aclk) disable iff (!aresetn)
        s_pd_reset |=> main_regulator_en && !$past(main_regulator_en))
        else $error("Wake-up did not restore main regulator.");
    a_pdown_regs: assert property (@(posedge aclk) disable iff (!aresetn)
        state == ST_PDOWN |-> !main_regulator_en && lp_regulator_en)
        else $error("Regulator enables wrong in power-down.");
    a_active_regs: assert property (@(posedge aclk) disable iff (!aresetn)
        state == ST_RUN |-> main_regulator_en && lp_regulator_en)
        else $error("Regulator enables wrong in active mode.");
    a_pin_reset_hw: assert property (@(posedge aclk) disable iff (!aresetn)
        state == ST_RUN && pin_reset && !brownout_detect
        |=> !system_reset_n && cur_cause[rbc_pkg::CAUSE_HW])
        else $error("Pin reset not taken as hardware reset.");
    a_pin_sync_delay: assert property (@(posedge aclk) disable iff (!aresetn)
        !reset_pin_n [*4] |=> pin_reset)
        else $error("Low reset pin not seen after sync delay.");
    a_watchdog_cause: assert property (@(posedge aclk) disable iff (!aresetn)
        state == ST_RUN && watchdog_timer_reset_req && !pin_reset
        && !brownout_detect |=> cur_cause[rbc_pkg::CAUSE_WDOG])
        else $error("Watchdog reset cause not recorded.");
    a_osc_default: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(system_reset_n) |=> !ext_osc_select)
        else $error("Oscillator not back on chip after reset.");
    a_debug_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_done && flash_protected |=> boot_mode != rbc_pkg::BOOT_DEBUG)
        else $error("Debug boot entered with flash protected.");
    a_boot_held: assert property (@(posedge aclk) disable iff (!aresetn)
        state == ST_RUN |=> $stable(boot_mode))
        else $error("Boot choice changed while running.");
    a_sequence_len: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(system_reset_n) |-> $past(state == ST_RESET, 16))
        else $error("Reset sequence shorter than hold time.");

endmodule : rbc_top

// >>> shared/rbc_pkg.sv
// Constants, types and the register map of the reset and boot controller.
// Assumes one 200 MHz clock and a 32-bit AXI4-Lite register port.
package rbc_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_PS     = 5000;
    localparam int PIN_MIN_LOW_NS    = 100;
    localparam int PIN_MIN_LOW_CYC   =
        (PIN_MIN_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RST_HOLD_CYC      = 16;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] CTRL_OFFSET   = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    localparam logic [3:0] CAUSE_OFFSET  = 4'h8;

    localparam int CTRL_EXT_OSC_BIT  = 0;
    localparam int CTRL_OSC_DISC_BIT = 1;
    localparam int CTRL_VCO_BYP_BIT  = 2;
    localparam int CTRL_PDOWN_BIT    = 3;
    localparam int CTRL_NDIV_LSB     = 8;
    localparam int NDIV_W            = 5;
    localparam logic [4:0] NDIV_RESET = 5'h0_010;

    localparam int STAT_BOOT_LSB     = 0;
    localparam int STAT_CLKMODE_LSB  = 4;
    localparam int STAT_OSC_FAIL_BIT = 8;
    localparam int STAT_UNLOCK_BIT   = 9;
    localparam int STAT_SRAM_OK_BIT  = 10;
    localparam int STAT_PDOWN_BIT    = 11;

    // ****************************************
    // Fixed divider factors and start address
    // ****************************************
    localparam logic [1:0]  DIV_P_FIXED  = 2'h1;
    localparam logic [1:0]  DIV_K_FIXED  = 2'h2;
    localparam logic [15:0] PC_START     = 16'h0000;

    // Reset cause one-hot bit positions.
    localparam int CAUSE_POR  = 0;
    localparam int CAUSE_HW   = 1;
    localparam int CAUSE_WDOG = 2;
    localparam int CAUSE_WAKE = 3;
    localparam int CAUSE_BO   = 4;
    localparam int CAUSE_N    = 5;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        BOOT_USER,
        BOOT_LOADER,
        BOOT_DEBUG,
        BOOT_USER_JTAG
    } rbc_boot_t;

    typedef enum logic [1:0] {
        CLK_PLL,
        CLK_PRESCALER,
        CLK_PLL_BASE
    } rbc_clk_mode_t;

endpackage : rbc_pkg

// >>> dv/rbc_board.sv
// Board model: pulses the external reset pin and drives the boot straps.
// Assumes the bench commands it on aclk; the pin idles high.
`timescale 1ns/1ps
module rbc_board (
    input  wire logic       aclk,
    input  wire logic       pulse_req,
    input  wire logic [7:0] pulse_len,
    input  wire logic [2:0] straps_req,
    output logic            reset_pin_n,
    output logic [2:0]      straps
);
    logic [7:0] low_cnt = 8'h00;

    // The pin is held low for the whole count; a new request reloads the count with pulse_len.
    always_ff @(posedge aclk)
    begin
        if (pulse_req)
            low_cnt <= pulse_len;
        else if (low_cnt != 8'h00)
            low_cnt <= low_cnt - 8'h01;
    end
    assign reset_pin_n = (low_cnt == 8'h00);

    // Straps follow straps_req one cycle later, even during a reset sequence.
    always_ff @(posedge aclk)
    begin
        straps <= straps_req;
    end
endmodule : rbc_board

// >>> dv/tb_rbc_top.sv
// Self-checking bench for the reset and boot controller.
// Assumes the board model drives the pin and straps; AXI4-Lite master here.
`timescale 1ns/1ps
module tb_rbc_top;
    logic        aclk = 0, aresetn = 0, pulse_req = 0, flash_protected = 0;
    logic        wd_req = 0, bo = 0, osc = 1, pll = 1, reset_pin_n;
    logic [2:0]  straps_req = 3'h4, straps;
    logic        system_reset_n, sram_preserved, main_regulator_en;
    logic        lp_regulator_en, ext_osc_select, clock_fault;
    logic [1:0]  clock_mode, div_p, div_k, boot_mode, bresp, rresp, rsp;
    logic [4:0]  feedback_ndiv;
    logic [15:0] pc_start;
    logic [3:0]  awaddr = 0, araddr = 0, wstrb = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic        rready = 0, awready, wready, bvalid, arready, rvalid;
    logic [1:0]  cm_exp [4] = '{rbc_pkg::CLK_PLL, rbc_pkg::CLK_PLL_BASE,
                                rbc_pkg::CLK_PRESCALER, rbc_pkg::CLK_PLL_BASE};
    int          err_count = 0, n_checks = 0;

    always #2.5 aclk = ~aclk;

    rbc_board board (.aclk(aclk), .pulse_req(pulse_req),
        .pulse_len(8'h14), .straps_req(straps_req),
        .reset_pin_n(reset_pin_n), .straps(straps));

    rbc_top dut (.aclk(aclk), .aresetn(aresetn), .reset_pin_n(reset_pin_n),
        .boot_mode_strap_pin(straps[2]), .jtag_mode_select(straps[1]),
        .port_zero_bit_zero_strap(straps[0]),
        .flash_protected(flash_protected), .watchdog_timer_reset_req(wd_req),
        .brownout_detect(bo), .osc_running(osc), .pll_locked(pll),
        .system_reset_n(system_reset_n), .sram_preserved(sram_preserved),
        .main_regulator_en(main_regulator_en),
        .lp_regulator_en(lp_regulator_en), .ext_osc_select(ext_osc_select),
        .clock_mode(clock_mode), .feedback_ndiv(feedback_ndiv),
        .div_p(div_p), .div_k(div_k), .boot_mode(boot_mode),
        .pc_start(pc_start), .clock_fault(clock_fault),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    task automatic fail_out();
        err_count++;
        give_verdict();
    endtask : fail_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int i;
        awaddr <= a; wdata <= d; wstrb <= 4'hF;
        awvalid <= 1; wvalid <= 1; bready <= 1;
        for (i = 0; i < 100; i++)
        begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 0;
            if (wready === 1'b1) wvalid <= 0;
            if (bvalid === 1'b1) break;
        end
        if (i == 100) fail_out();
        rsp = bresp;
    endtask : wr

    task automatic rdr(input logic [3:0] a);
        int i;
        araddr <= a; arvalid <= 1; rready <= 1;
        for (i = 0; i < 100; i++)
        begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 0;
            if (rvalid === 1'b1) break;
        end
        if (i == 100) fail_out();
        rd = rdata;
        rsp = rresp;
    endtask : rdr

    // Waits for a reset to start, then for the core to be let go again.
    task automatic wait_run();
        int i, j;
        for (i = 0; i < 300 && system_reset_n !== 1'b0; i++) @(posedge aclk);
        for (j = 0; j < 300 && system_reset_n !== 1'b1; j++) @(posedge aclk);
        if (i == 300 || j == 300) fail_out();
    endtask : wait_run

    task automatic cause_is(input logic [31:0] exp, input logic keep);
        rdr(rbc_pkg::CAUSE_OFFSET);
        chk(rd & 32'h0000_001F, exp);
        chk(32'(sram_preserved), 32'(keep));
        wr(rbc_pkg::CAUSE_OFFSET, 32'h0000_031F);
    endtask : cause_is

    task automatic pin_boot(input logic [2:0] s, input logic p,
                            input logic [1:0] m);
        straps_req <= s; flash_protected <= p; pulse_req <= 1;
        @(posedge aclk);
        pulse_req <= 0;
        wait_run();
        rdr(rbc_pkg::STATUS_OFFSET);
        chk(32'(rd[1:0]), 32'(m));
        chk(32'(boot_mode), 32'(m));
        chk({ext_osc_select, feedback_ndiv}, {1'b0, rbc_pkg::NDIV_RESET});
        cause_is(32'h0000_0002, 1'b1);
    endtask : pin_boot

    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        wait_run();
        chk({main_regulator_en, lp_regulator_en}, 2'h3);
        chk({div_p, div_k}, {rbc_pkg::DIV_P_FIXED, rbc_pkg::DIV_K_FIXED});
        chk(32'(pc_start), 32'h0000_0000);
        chk(32'(boot_mode), 32'(rbc_pkg::BOOT_USER));
        chk(32'(ext_osc_select), 32'h0000_0000);
        cause_is(32'h0000_0001, 1'b0);
        for (int m = 0; m < 4; m++)
        begin
            wr(rbc_pkg::CTRL_OFFSET, 32'h0000_1000 | (32'(m) << 1));
            chk(32'(clock_mode), 32'(cm_exp[m]));
        end
        wr(rbc_pkg::CTRL_OFFSET, 32'h0000_1401);
        rdr(rbc_pkg::CTRL_OFFSET);
        chk(rd, 32'h0000_1401);
        chk({ext_osc_select, feedback_ndiv}, 6'h34);
        pin_boot(3'h0, 1'b0, rbc_pkg::BOOT_LOADER);
        pin_boot(3'h2, 1'b0, rbc_pkg::BOOT_DEBUG);
        pin_boot(3'h2, 1'b1, rbc_pkg::BOOT_USER);
        pin_boot(3'h6, 1'b0, rbc_pkg::BOOT_USER_JTAG);
        pin_boot(3'h5, 1'b0, rbc_pkg::BOOT_USER);
        // A watchdog reset must not pick up the changed straps.
        straps_req <= 3'h0; wd_req <= 1;
        @(posedge aclk);
        wd_req <= 0;
        wait_run();
        chk(32'(boot_mode), 32'(rbc_pkg::BOOT_USER));
        cause_is(32'h0000_0004, 1'b1);
        wr(rbc_pkg::CTRL_OFFSET, 32'h0000_1008);
        rdr(rbc_pkg::STATUS_OFFSET);
        chk(32'(rd[11]), 32'h0000_0001);
        chk({main_regulator_en, lp_regulator_en}, 2'h1);
        pulse_req <= 1;
        @(posedge aclk);
        pulse_req <= 0;
        wait_run();
        chk({main_regulator_en, lp_regulator_en}, 2'h3);
        cause_is(32'h0000_0008, 1'b1);
        osc <= 0;
        @(posedge aclk);
        rdr(rbc_pkg::STATUS_OFFSET);
        chk({clock_fault, rd[9:8]}, 3'h5);
        osc <= 1; pll <= 0;
        wr(rbc_pkg::CAUSE_OFFSET, 32'h0000_0100);
        rdr(rbc_pkg::STATUS_OFFSET);
        chk({clock_fault, rd[9:8]}, 3'h6);
        pll <= 1;
        wr(rbc_pkg::CAUSE_OFFSET, 32'h0000_0200);
        chk(32'(clock_fault), 32'h0000_0000);
        bo <= 1;
        repeat (5) @(posedge aclk);
        bo <= 0;
        wait_run();
        cause_is(32'h0000_0010, 1'b0);
        rdr(4'hC);
        chk(32'(rsp), 32'(rbc_pkg::RESP_SLVERR));
        wr(4'hC, 32'h0000_FFFF);
        chk(32'(rsp), 32'(rbc_pkg::RESP_SLVERR));
        give_verdict();
    end
endmodule : tb_rbc_top
